//--- design/ctrl_in_ep_consts.svh
`ifndef CTRL_IN_EP_CONSTS_SVH
`define CTRL_IN_EP_CONSTS_SVH

`define HADDR_W 18
`define CFG_IDX 16'hFF80
`define BCNT_IDX 16'hFF81
`define IN_BUF_IDX 16'hFEF8
`define OUT_BUF_IDX 16'hFEF0
`define BUF_IDX_MASK 16'hFFF8

`define CFG_ENABLE_BIT 7
`define CFG_TOGGLE_BIT 5
`define CFG_STALL_BIT 3
`define CFG_IRQEN_BIT 2
`define BCNT_NAK_BIT 7
`define BCNT_CNT_MSB 3

`define MAX_PKT_LEN 4'h8
`define NAK_RESET 1'b1
`define TOGGLE_RESET 1'b0
`define COUNT_RESET 4'h0

`endif

//--- design/ctrl_in_ep_pkg.sv
package ctrl_in_ep_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_PUT,
    ST_SEND,
    ST_WAIT_ACK
  } ep_fsm_e;

  typedef enum logic [1:0] {
    RESP_NONE,
    RESP_DATA,
    RESP_NAK,
    RESP_STALL
  } resp_e;

  typedef struct packed {
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic ap_valid;
    logic ap_write;
    logic [15:0] ap_idx;
    logic enable;
    logic stall;
    logic irq_en;
    logic toggle;
    logic nak;
    logic [3:0] count;
    ep_fsm_e state;
    logic [2:0] idx;
    logic [3:0] len;
    logic resp_valid;
    resp_e resp_kind;
    logic resp_data1;
    logic [3:0] resp_len;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_last;
    logic irq;
  } ep_state_s;

endpackage : ctrl_in_ep_pkg

//--- design/ep_buf_mem.sv
`timescale 1ns/1ps
`default_nettype none

module ep_buf_mem #(
  parameter int DW = 8,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr_a,
  output logic [DW-1:0] rd_data_a,
  input wire logic [AW-1:0] rd_addr_b,
  output logic [DW-1:0] rd_data_b
);

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] cells;
    logic [DW-1:0] rda;
    logic [DW-1:0] rdb;
  } mem_state_s;

  mem_state_s mem_ff;
  mem_state_s nxt_mem;

  always_comb begin
    nxt_mem = mem_ff;
    // Two registered read ports so the bus never waits on the packet engine
    nxt_mem.rda = mem_ff.cells[rd_addr_a];
    nxt_mem.rdb = mem_ff.cells[rd_addr_b];
    if (wr_en) begin
      nxt_mem.cells[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ff <= '0;
    end else if (ce) begin
      mem_ff <= nxt_mem;
    end
  end

  assign rd_data_a = mem_ff.rda;
  assign rd_data_b = mem_ff.rdb;

endmodule : ep_buf_mem

`default_nettype wire

//--- design/ctrl_in_endpoint.sv
`include "ctrl_in_ep_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module ctrl_in_endpoint
  import ctrl_in_ep_pkg::*;
#(
  parameter int BUF_DEPTH = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [`HADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic in_token,
  input wire logic setup_token,
  input wire logic host_ack,
  input wire logic host_abort,
  output logic resp_valid,
  output logic [1:0] resp_kind,
  output logic resp_data1,
  output logic [3:0] resp_len,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  output logic completion_irq
);

  ep_state_s s_ff;
  ep_state_s nxt_s;

  logic mem_wr_en;
  logic [2:0] mem_wr_addr;
  logic [7:0] mem_wr_data;
  logic [7:0] mem_rd_a;
  logic [7:0] mem_rd_b;
  logic ack_done;
  logic bus_take;

  function automatic logic [3:0] eff_len(input logic [3:0] code);
    if (code > `MAX_PKT_LEN) begin
      eff_len = `MAX_PKT_LEN;
    end else begin
      eff_len = code;
    end
  endfunction : eff_len

  function automatic logic buf_hit(input logic [15:0] idx);
    buf_hit = (idx & `BUF_IDX_MASK) == `IN_BUF_IDX;
  endfunction : buf_hit

  function automatic logic is_cfg(input logic [15:0] idx);
    is_cfg = (idx == `CFG_IDX);
  endfunction : is_cfg

  function automatic logic is_bcnt(input logic [15:0] idx);
    is_bcnt = (idx == `BCNT_IDX);
  endfunction : is_bcnt

  // Reserved positions stay zero on every read
  function automatic logic [31:0] cfg_word(
    input logic enable,
    input logic toggle,
    input logic stall,
    input logic irq_en
  );
    cfg_word = 32'h0000_0000;
    cfg_word[`CFG_ENABLE_BIT] = enable;
    cfg_word[`CFG_TOGGLE_BIT] = toggle;
    cfg_word[`CFG_STALL_BIT] = stall;
    cfg_word[`CFG_IRQEN_BIT] = irq_en;
  endfunction : cfg_word

  function automatic logic [31:0] bcnt_word(input logic nak, input logic [3:0] count);
    bcnt_word = 32'h0000_0000;
    bcnt_word[`BCNT_NAK_BIT] = nak;
    bcnt_word[`BCNT_CNT_MSB:0] = count;
  endfunction : bcnt_word

  // Stall outranks an empty buffer, which outranks data
  function automatic resp_e answer_kind(input logic stall, input logic nak);
    if (stall) begin
      answer_kind = RESP_STALL;
    end else if (nak) begin
      answer_kind = RESP_NAK;
    end else begin
      answer_kind = RESP_DATA;
    end
  endfunction : answer_kind

  function automatic logic last_byte(input logic [2:0] idx, input logic [3:0] len);
    last_byte = ({1'b0, idx} == (len - 4'h1));
  endfunction : last_byte

  // Output buffer lives with the output endpoint; only the input window decodes here
  ep_buf_mem #(
    .DW(8),
    .DEPTH(BUF_DEPTH),
    .AW(3)
  ) u_buf (
    .clk(hclk),
    .rst_n(hresetn),
    .ce(ce),
    .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr),
    .wr_data(mem_wr_data),
    .rd_addr_a(haddr[4:2]),
    .rd_data_a(mem_rd_a),
    .rd_addr_b(s_ff.idx),
    .rd_data_b(mem_rd_b)
  );

  assign bus_take = hsel && htrans[1] && hready;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.resp_valid = 1'b0;
    nxt_s.irq = 1'b0;
    nxt_s.hresp = 1'b0;
    ack_done = 1'b0;
    mem_wr_en = 1'b0;
    mem_wr_addr = s_ff.ap_idx[2:0];
    mem_wr_data = hwdata[7:0];

    // Packet engine
    case (s_ff.state)
      ST_IDLE: begin
        if (in_token && s_ff.enable) begin
          nxt_s.resp_valid = 1'b1;
          nxt_s.resp_data1 = s_ff.toggle;
          nxt_s.resp_len = 4'h0;
          nxt_s.resp_kind = answer_kind(s_ff.stall, s_ff.nak);
          if (!s_ff.stall && !s_ff.nak) begin
            nxt_s.resp_len = eff_len(s_ff.count);
            nxt_s.len = eff_len(s_ff.count);
            nxt_s.idx = 3'h0;
            nxt_s.state = (eff_len(s_ff.count) == 4'h0) ? ST_WAIT_ACK : ST_LOAD;
          end
        end
      end
      ST_LOAD: begin
        nxt_s.state = ST_PUT;
      end
      ST_PUT: begin
        nxt_s.tx_data = mem_rd_b;
        nxt_s.tx_valid = 1'b1;
        nxt_s.tx_last = last_byte(s_ff.idx, s_ff.len);
        nxt_s.state = ST_SEND;
      end
      ST_SEND: begin
        if (tx_ready) begin
          nxt_s.tx_valid = 1'b0;
          nxt_s.tx_last = 1'b0;
          if (s_ff.tx_last) begin
            nxt_s.state = ST_WAIT_ACK;
          end else begin
            nxt_s.idx = s_ff.idx + 3'h1;
            nxt_s.state = ST_LOAD;
          end
        end
      end
      ST_WAIT_ACK: begin
        if (host_ack) begin
          ack_done = 1'b1;
          nxt_s.state = ST_IDLE;
        end
      end
      default: begin
        nxt_s.state = ST_IDLE;
      end
    endcase

    // Lost handshake keeps the packet for a retry
    if (host_abort && s_ff.state != ST_IDLE && !ack_done) begin
      nxt_s.state = ST_IDLE;
      nxt_s.tx_valid = 1'b0;
      nxt_s.tx_last = 1'b0;
    end

    if (ack_done) begin
      nxt_s.toggle = ~s_ff.toggle;
      nxt_s.irq = s_ff.irq_en;
    end

    // Setup restarts the control pipe: data stage begins with DATA1
    if (setup_token) begin
      nxt_s.stall = 1'b0;
      nxt_s.toggle = 1'b1;
      nxt_s.state = ST_IDLE;
      nxt_s.tx_valid = 1'b0;
      nxt_s.tx_last = 1'b0;
    end

    // Bus data phase; firmware stall set wins over the setup clear
    if (s_ff.ap_valid) begin
      if (s_ff.ap_write) begin
        if (is_cfg(s_ff.ap_idx)) begin
          nxt_s.enable = hwdata[`CFG_ENABLE_BIT];
          nxt_s.stall = hwdata[`CFG_STALL_BIT];
          nxt_s.irq_en = hwdata[`CFG_IRQEN_BIT];
        end else if (is_bcnt(s_ff.ap_idx)) begin
          nxt_s.nak = hwdata[`BCNT_NAK_BIT];
          nxt_s.count = hwdata[`BCNT_CNT_MSB:0];
        end else if (buf_hit(s_ff.ap_idx)) begin
          mem_wr_en = 1'b1;
        end
      end else begin
        nxt_s.hreadyout = 1'b1;
        nxt_s.hrdata = 32'h0000_0000;
        if (is_cfg(s_ff.ap_idx)) begin
          nxt_s.hrdata = cfg_word(s_ff.enable, s_ff.toggle, s_ff.stall, s_ff.irq_en);
        end else if (is_bcnt(s_ff.ap_idx)) begin
          nxt_s.hrdata = bcnt_word(s_ff.nak, s_ff.count);
        end else if (buf_hit(s_ff.ap_idx)) begin
          nxt_s.hrdata[7:0] = mem_rd_a;
        end
      end
    end

    // Completion marks the buffer empty; beats a same-cycle firmware clear
    if (ack_done) begin
      nxt_s.nak = 1'b1;
    end

    // Address phase: reads take one wait state for the registered buffer port
    nxt_s.ap_valid = 1'b0;
    if (bus_take) begin
      nxt_s.ap_valid = 1'b1;
      nxt_s.ap_write = hwrite;
      nxt_s.ap_idx = haddr[`HADDR_W-1:2];
      if (!hwrite) begin
        nxt_s.hreadyout = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_ff <= '0;
      s_ff.hreadyout <= 1'b1;
      s_ff.nak <= `NAK_RESET;
      s_ff.count <= `COUNT_RESET;
      s_ff.toggle <= `TOGGLE_RESET;
      s_ff.state <= ST_IDLE;
      s_ff.resp_kind <= RESP_NONE;
      // Endpoint comes up disabled, unstalled and silent
      s_ff.enable <= 1'b0;
      s_ff.stall <= 1'b0;
      s_ff.irq_en <= 1'b0;
      s_ff.tx_valid <= 1'b0;
      s_ff.resp_valid <= 1'b0;
      s_ff.irq <= 1'b0;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  assign hreadyout = s_ff.hreadyout;
  assign hrdata = s_ff.hrdata;
  assign hresp = s_ff.hresp;
  assign resp_valid = s_ff.resp_valid;
  assign resp_kind = s_ff.resp_kind;
  assign resp_data1 = s_ff.resp_data1;
  assign resp_len = s_ff.resp_len;
  assign tx_valid = s_ff.tx_valid;
  assign tx_data = s_ff.tx_data;
  assign tx_last = s_ff.tx_last;
  assign completion_irq = s_ff.irq;

endmodule : ctrl_in_endpoint

`default_nettype wire

//--- tb/ctrl_in_endpoint_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ctrl_in_endpoint_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic in_token,
  input wire logic host_ack,
  input wire logic resp_valid,
  input wire logic [1:0] resp_kind,
  input wire logic [3:0] resp_len,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic completion_irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_ANS: assert property (resp_valid |-> $past(in_token)) else $error("answer w/o token");
  AST_LEN: assert property (resp_valid |-> resp_len <= 4'h8) else $error("len over 8");
  AST_HS0: assert property (resp_valid && resp_kind != 2'h1 |-> resp_len == 4'h0) else $error("hs len");
  AST_BYTE: assert property (resp_valid && resp_kind == 2'h1 && resp_len != 0 |-> ##2 tx_valid)
    else $error("no first byte");
  AST_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("tx drop");
  AST_IRQ: assert property (completion_irq |-> $past(host_ack)) else $error("irq w/o ack");
  AST_RD: assert property (hsel && htrans[1] && hreadyout && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait");
  AST_RSV: assert property ($rose(hreadyout) |-> hrdata[31:8] == 24'h0) else $error("rsv bits");
endmodule : ctrl_in_endpoint_assertions
bind ctrl_in_endpoint ctrl_in_endpoint_assertions u_chk (.*);
`default_nettype wire

//--- tb/usb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
  input wire logic hclk,
  input wire logic resp_valid,
  input wire logic [1:0] resp_kind,
  input wire logic resp_data1,
  input wire logic [3:0] resp_len,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic in_token,
  output logic setup_token,
  output logic host_ack,
  output logic host_abort,
  output logic tx_ready
);
  initial {in_token, setup_token, host_ack, host_abort, tx_ready} = 5'h0;
  task automatic setup;
    @(posedge hclk);
    setup_token <= 1;
    @(posedge hclk);
    setup_token <= 0;
  endtask : setup
  task automatic xfer(input bit slow, output logic [1:0] k, output logic d1, output logic [63:0] b, output int n);
    int t;
    k = 0;
    n = 0;
    @(posedge hclk);
    in_token <= 1;
    @(posedge hclk);
    in_token <= 0;
    for (t = 0; t < 4 && !resp_valid; t++) @(posedge hclk);
    if (!resp_valid) return;
    k = resp_kind;
    d1 = resp_data1;
    // STALL or NAK ends it, no ack from us
    if (k != 2'h1) return;
    if (resp_len != 0) tx_ready <= !slow;
    for (t = 0; t < 99 && n < resp_len; t++) begin
      @(posedge hclk);
      if (tx_valid && tx_ready) begin
        b[8*n +: 8] = tx_data;
        n++;
      end
      // Slow sink stalls every other cycle
      if (slow && n < resp_len) tx_ready <= ~tx_ready;
    end
    tx_ready <= 0;
    host_ack <= 1;
    @(posedge hclk);
    host_ack <= 0;
  endtask : xfer
endmodule : usb_host_model
`default_nettype wire

//--- tb/tb_ctrl_in_endpoint.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctrl_in_ep_consts.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; $display("BAD %0t %h", $time, a); end end
module tb_ctrl_in_endpoint;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, d1;
  logic [1:0] htrans = 0, k;
  logic [17:0] haddr = 0;
  logic [31:0] hwdata = 0, hrdata, r;
  logic hreadyout, hresp, in_token, setup_token, host_ack, host_abort, tx_ready;
  logic resp_valid, resp_data1, tx_valid, tx_last, completion_irq;
  logic [1:0] resp_kind;
  logic [3:0] resp_len;
  logic [7:0] tx_data;
  logic [63:0] b;
  int n, failures = 0, checked = 0, irqs = 0, lasts = 0;
  ctrl_in_endpoint u_dut (.ce(1'b1), .hsize(3'h2), .hready(hreadyout), .*);
  usb_host_model u_host (.*);
  initial forever #5 hclk = ~hclk;
  always @(posedge hclk) if (completion_irq === 1'b1) irqs++;
  always @(posedge hclk) if (tx_valid === 1'b1 && tx_ready === 1'b1 && tx_last === 1'b1) lasts++;
  task automatic ahb(input bit w, input logic [15:0] i, input logic [7:0] d);
    int t;
    t = 0;
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {i, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++t < 50);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++t < 50);
    r = hrdata;
    hsel <= 0;
    if (t >= 50) begin
      failures++;
      stop_test();
    end
  endtask : ahb
  task automatic rd(input logic [15:0] i, input logic [7:0] e);
    ahb(0, i, 0);
    `CHK(r, {24'h0, e})
    `CHK(hresp, 1'b0)
  endtask : rd
  task automatic t_reset;
    rd(`CFG_IDX, 8'h00);
    rd(`BCNT_IDX, 8'h80);
    rd(16'h0000, 8'h00);
    ahb(1, `CFG_IDX, 8'hFF);
    rd(`CFG_IDX, 8'h8C);
    ahb(1, `CFG_IDX, 8'h00);
    ahb(1, `BCNT_IDX, 8'h01);
    u_host.xfer(0, k, d1, b, n);
    `CHK(k, 2'h0)
    ahb(1, `CFG_IDX, 8'h84);
    ahb(1, `BCNT_IDX, 8'h85);
    u_host.xfer(0, k, d1, b, n);
    `CHK(k, 2'h2)
    `CHK(irqs, 0)
    $display("reset, disable and nak done");
  endtask : t_reset
  task automatic t_data(input logic [7:0] c, input logic [3:0] code, input int len, input logic e1, input bit s);
    int i0;
    int l0;
    for (int i = 0; i < 8; i++) ahb(1, `IN_BUF_IDX + 16'(i), 8'hA0 + 8'(i));
    rd(`IN_BUF_IDX + 16'h7, 8'hA7);
    ahb(1, `CFG_IDX, c);
    ahb(1, `BCNT_IDX, {4'h0, code});
    i0 = irqs;
    l0 = lasts;
    u_host.xfer(s, k, d1, b, n);
    `CHK(k, 2'h1)
    `CHK(d1, e1)
    `CHK(n, len)
    `CHK(lasts - l0, int'(len != 0))
    for (int i = 0; i < len; i++) `CHK(b[8*i +: 8], 8'hA0 + 8'(i))
    rd(`BCNT_IDX, {4'h8, code});
    rd(`CFG_IDX, {c[7:6], ~e1, c[4:0]});
    `CHK(irqs - i0, int'(c[2]))
    $display("data test done");
  endtask : t_data
  task automatic t_stall;
    ahb(1, `CFG_IDX, 8'h88);
    ahb(1, `BCNT_IDX, 8'h02);
    u_host.xfer(0, k, d1, b, n);
    `CHK(k, 2'h3)
    u_host.setup();
    rd(`CFG_IDX, 8'hA0);
    u_host.xfer(0, k, d1, b, n);
    `CHK(k, 2'h1)
    `CHK(d1, 1'b1)
    `CHK(n, 2)
    $display("stall test done");
  endtask : t_stall
  task automatic stop_test;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    t_reset();
    t_data(8'h84, 4'hF, 8, 1'b0, 1);
    t_data(8'h80, 4'h0, 0, 1'b1, 0);
    t_data(8'h80, 4'h3, 3, 1'b0, 0);
    t_stall();
    stop_test();
  end
  initial begin
    #100us;
    failures++;
    stop_test();
  end
endmodule : tb_ctrl_in_endpoint
`default_nettype wire
